//--- src/serializer_sideband_control.sv
// Sideband control and status register bank of the video serializer
//
// Operation
// [R01] Auto power-down sleeps without back channel, retries
// [R02] Forward channel resumes only after bit cleared
// [R03] Remote wake uses pass-through and auto-acknowledge
// [R04] Sleep on pixel clock loss when enabled
// [R05] Clock lost below about one megahertz
// [R06] Relock automatically when pixel clock returns
// [R07] Registers retained while pixel clock absent
// [R08] Any of six link faults clears detect
// [R09] Edge select picks rising or falling capture
// [R10] Band pin and alternate setting choose mode
// [R11] Mirror output follows remote interrupt input
// [R12] Mirror held low until downstream lock
// [R13] Routed remote interrupt pulls local interrupt low
// [R14] Status read clears and releases interrupt
// [R15] Host reads status, clears downstream source
// [R16] Mirror users keep routing bit low
// [R17] Test pattern runs without input, oscillator fallback
// [R18] Eighteen-bit mode frees four lines as GPIO
// [R19] Eighteen-bit mode set locally, propagated downstream
// [R20] Direction codes written per line nibble
// [R21] General outputs 4 and 5 become inputs
// [R22] General outputs 7 to 4 from register bits
module serializer_sideband_control
	import sideband_pkg::*;
	#(
	parameter logic [6:0] I2C_DEV_ADDR = 7'h0C // Arbitrary bus address
)(
	input wire logic CLOCK, // System clock, 100 MHz
	input wire logic ARST_N, // Asynchronous reset, active low
	input wire logic SCL_IN, // I2C clock pin
	input wire logic SDA_IN, // I2C data pin level
	output logic SDA_OE, // I2C data pulled low while high
	output logic SDA_OUT, // I2C data drive level, always low
	input wire logic REMOTE_WR_EN, // Back channel register write strobe
	input wire logic [7:0] REMOTE_ADDR, // Back channel register offset
	input wire logic [7:0] REMOTE_WDATA, // Back channel write data
	input wire logic PCLK_IN, // Pixel clock pin, sampled
	input wire logic [23:0] PIXEL_DATA, // Parallel pixel inputs
	output logic [23:0] CAPTURED_DATA, // Pixel word on selected edge
	input wire logic BACK_CHANNEL_DET, // Back channel activity seen
	input wire logic [5:0] LINK_FAULT, // Link fault detector flags
	input wire logic DOWNSTREAM_LOCK, // Downstream deserializer locked
	input wire logic DOWNSTREAM_INTERRUPT_IN_N, // Remote interrupt input state
	output logic REMOTE_INTERRUPT_MIRROR_N, // Remote interrupt mirror
	output logic LOCAL_INTERRUPT_N, // Local interrupt, active low
	input wire logic FREQUENCY_BAND_PIN, // Band select pin
	input wire logic ALT_FREQ_PIN, // Alternate frequency strap
	output logic HIGH_BAND_SETTING, // High band mode
	output logic MIDDLE_BAND_SETTING, // Intermediate band mode
	output logic LOW_BAND_SETTING, // Low band mode
	output logic FORWARD_ENABLE, // Forward channel running
	output logic APD_LOW_POWER, // Remote auto power-down sleeping
	output logic APD_RETRY, // Back channel seen, wake pending
	output logic PCLK_SLEEP, // Sleep on lost pixel clock
	output logic TX_PATTERN, // Send internal test pattern
	output logic TX_USE_OSC, // Pattern timed by oscillator
	output logic DOWNSTREAM_18BIT, // Eighteen-bit mode to far end
	input wire logic [3:0] BACK_GPIO, // Back channel GPIO values
	input wire logic [7:4] LINE_IN, // General output pin levels
	output logic [7:0] LINE_OUT, // Line drive levels
	output logic [7:0] LINE_OE, // Line drive enables
	output logic [7:0] FWD_LINE // Line values to forward channel
);
	logic [SYNC_W-1:0] sync_in, sync_out;
	logic pclk_s, bc_s, lock_s, int_n_s, frequency_band_pin_pin_s, alt_pin_s, scl_s, sda_s;
	logic [23:0] data_s;
	logic [5:0] fault_s;
	logic [3:0] back_gpio_s;
	logic [7:4] line_in_s;
	logic [7:0] dev_ctl_ff, clk_ctl_ff, alt_ovr_ff, gpio0_ff, gpio12_ff, gpio3_ff, out56_ff, out7_ff;
	logic [7:0] depth_ff, frequency_band_pin_ovr_ff, icr_ff;
	logic loc_wr, loc_rd, any_wr;
	logic [7:0] loc_addr, loc_wdata, wr_addr, wr_data, rd_data;
	apd_state_t apd_ff;
	logic pclk_prev_ff, pclk_lost_ff, link_ok_ff, int_prev_ff, remote_pend_ff;
	logic [7:0] loss_cnt_ff;
	logic pclk_rise, pclk_fall, remote_fall, isr_read, frequency_band_pin_eff, alt_eff, mode18;
	logic [3:0] line_cfg [8];

	// All pins except reset and the back channel write port cross into the clock domain through two flops
	assign sync_in = {SCL_IN, SDA_IN, ALT_FREQ_PIN, FREQUENCY_BAND_PIN, LINE_IN, BACK_GPIO,
		DOWNSTREAM_INTERRUPT_IN_N, DOWNSTREAM_LOCK, LINK_FAULT, BACK_CHANNEL_DET, PIXEL_DATA, PCLK_IN};
	assign {scl_s, sda_s, alt_pin_s, frequency_band_pin_pin_s, line_in_s, back_gpio_s, int_n_s, lock_s, fault_s, bc_s,
		data_s, pclk_s} = sync_out;

	sideband_sync #(
		.W(SYNC_W),
		.RST_VAL(SYNC_RST)
	) u_sync (
		.clk(CLOCK),
		.arst_n(ARST_N),
		.din(sync_in),
		.dout(sync_out)
	);

	sideband_i2c_slave #(
		.DEV_ADDR(I2C_DEV_ADDR)
	) u_i2c (
		.clk(CLOCK),
		.arst_n(ARST_N),
		.scl(scl_s),
		.sda(sda_s),
		.sda_oe(SDA_OE),
		.wr_en(loc_wr),
		.rd_en(loc_rd),
		.addr(loc_addr),
		.wdata(loc_wdata),
		.rdata(rd_data)
	);

	assign SDA_OUT = 1'b0;

	// Local host wins a same-cycle collision with a back channel write
	assign any_wr = loc_wr || REMOTE_WR_EN;
	assign wr_addr = loc_wr ? loc_addr : REMOTE_ADDR;
	assign wr_data = loc_wr ? loc_wdata : REMOTE_WDATA;
	assign isr_read = loc_rd && (loc_addr == OFS_INTERRUPT_STATUS);

	// Writable registers; clocked by the system clock so pixel clock loss never disturbs them (see [R07])
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			dev_ctl_ff <= RST_DEVICE_CONTROL;
			clk_ctl_ff <= RST_CLOCK_LOSS_CONTROL;
			alt_ovr_ff <= RST_CONFIG;
			gpio0_ff <= RST_CONFIG;
			gpio12_ff <= RST_CONFIG;
			gpio3_ff <= RST_CONFIG;
			out56_ff <= RST_CONFIG;
			out7_ff <= RST_CONFIG;
			depth_ff <= RST_CONFIG;
			frequency_band_pin_ovr_ff <= RST_CONFIG;
			icr_ff <= RST_INTERRUPT_CONTROL;
		end else if (any_wr) begin
			case (wr_addr)
				OFS_DEVICE_CONTROL: dev_ctl_ff <= wr_data; // Clearing bit 7 wakes (see [R02])
				OFS_CLOCK_LOSS_CONTROL: clk_ctl_ff <= wr_data;
				OFS_ALT_FREQ_OVERRIDE: alt_ovr_ff <= wr_data;
				OFS_GPIO0_CONFIG: gpio0_ff <= wr_data; // see [R20]
				OFS_GPIO1_2_CONFIG: gpio12_ff <= wr_data;
				OFS_GPIO3_OUT4_CONFIG: gpio3_ff <= wr_data;
				OFS_OUT5_6_CONFIG: out56_ff <= wr_data;
				OFS_OUT7_CONFIG: out7_ff <= wr_data;
				OFS_COLOUR_DEPTH: depth_ff <= wr_data; // see [R19]
				OFS_FREQ_SEL_OVERRIDE: frequency_band_pin_ovr_ff <= wr_data;
				OFS_INTERRUPT_CONTROL: icr_ff <= wr_data;
				default: ; // Status and unmapped offsets ignore writes
			endcase
		end
	end

	// Read data at the pointer; unmapped offsets read zero
	always_comb begin
		case (loc_addr)
			OFS_DEVICE_CONTROL: rd_data = dev_ctl_ff;
			OFS_CLOCK_LOSS_CONTROL: rd_data = clk_ctl_ff;
			OFS_ALT_FREQ_OVERRIDE: rd_data = alt_ovr_ff;
			OFS_LINK_STATUS: rd_data = {6'h00, !pclk_lost_ff, link_ok_ff};
			OFS_GPIO0_CONFIG: rd_data = gpio0_ff;
			OFS_GPIO1_2_CONFIG: rd_data = gpio12_ff;
			OFS_GPIO3_OUT4_CONFIG: rd_data = gpio3_ff;
			OFS_OUT5_6_CONFIG: rd_data = out56_ff;
			OFS_OUT7_CONFIG: rd_data = out7_ff;
			OFS_COLOUR_DEPTH: rd_data = depth_ff;
			OFS_FREQ_SEL_OVERRIDE: rd_data = frequency_band_pin_ovr_ff;
			OFS_INTERRUPT_CONTROL: rd_data = icr_ff;
			OFS_INTERRUPT_STATUS: rd_data = {2'h0, remote_pend_ff, 4'h0, remote_pend_ff};
			default: rd_data = 8'h00;
		endcase
	end

	// Remote auto power-down: sleep without back channel, leave only when software clears the enable
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			apd_ff <= APD_RUN;
		end else begin
			case (apd_ff)
				APD_RUN: if (dev_ctl_ff[APD_ENABLE_BIT] && !bc_s) apd_ff <= APD_SLEEP; // see [R01]
				APD_SLEEP: begin
					if (!dev_ctl_ff[APD_ENABLE_BIT]) apd_ff <= APD_RUN; // see [R02]
					else if (bc_s) apd_ff <= APD_WAKE; // see [R01]
				end
				APD_WAKE: begin
					// Waits here for the remote or local clear of the enable (see [R03])
					if (!dev_ctl_ff[APD_ENABLE_BIT]) apd_ff <= APD_RUN; // see [R02]
					else if (!bc_s) apd_ff <= APD_SLEEP;
				end
				default: apd_ff <= APD_RUN;
			endcase
		end
	end

	assign FORWARD_ENABLE = (apd_ff == APD_RUN);
	assign APD_LOW_POWER = (apd_ff != APD_RUN);
	assign APD_RETRY = (apd_ff == APD_WAKE);

	assign pclk_rise = pclk_s && !pclk_prev_ff;
	assign pclk_fall = !pclk_s && pclk_prev_ff;

	// Pixel clock watchdog: no edge for one microsecond means the clock is gone
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			pclk_prev_ff <= 1'b0;
			loss_cnt_ff <= 8'h00;
			pclk_lost_ff <= 1'b1;
		end else begin
			pclk_prev_ff <= pclk_s;
			if (pclk_rise || pclk_fall) begin
				loss_cnt_ff <= 8'h00;
				pclk_lost_ff <= 1'b0; // Relock needs no software (see [R06])
			end else if (loss_cnt_ff == 8'(PCLK_LOSS_CYCLES - 1)) begin
				pclk_lost_ff <= 1'b1; // see [R05]
			end else begin
				loss_cnt_ff <= loss_cnt_ff + 8'h01;
			end
		end
	end

	assign PCLK_SLEEP = clk_ctl_ff[SLEEP_ON_LOSS_BIT] && pclk_lost_ff; // see [R04]

	// Pattern keeps running without pixel input while powered; oscillator only when clock lost
	assign TX_PATTERN = FORWARD_ENABLE && clk_ctl_ff[PATTERN_ENABLE_BIT]; // see [R17]
	assign TX_USE_OSC = TX_PATTERN && clk_ctl_ff[PATTERN_OSC_BIT] && pclk_lost_ff; // see [R17]

	// Input capture on the selected pixel clock edge
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			CAPTURED_DATA <= 24'h000000;
		end else if (clk_ctl_ff[EDGE_SELECT_BIT] ? pclk_rise : pclk_fall) begin
			CAPTURED_DATA <= data_s; // see [R09]
		end
	end

	// Link detect drops on any fault or with no back channel
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			link_ok_ff <= 1'b0;
		end else begin
			link_ok_ff <= bc_s && !(|fault_s); // see [R08]
		end
	end

	// Band decode from each pin unless its own override is enabled
	assign frequency_band_pin_eff = frequency_band_pin_ovr_ff[FREQUENCY_BAND_PIN_OVR_EN_BIT] ? frequency_band_pin_ovr_ff[FREQUENCY_BAND_PIN_OVR_VAL_BIT] : frequency_band_pin_pin_s;
	assign alt_eff = alt_ovr_ff[ALT_OVR_EN_BIT] ? alt_ovr_ff[ALT_OVR_VAL_BIT] : alt_pin_s;
	assign HIGH_BAND_SETTING = !alt_eff; // see [R10]
	assign MIDDLE_BAND_SETTING = frequency_band_pin_eff && alt_eff; // see [R10]
	assign LOW_BAND_SETTING = !frequency_band_pin_eff && alt_eff; // see [R10]

	// Remote interrupt: mirror and routed sticky status; a new edge beats a clearing read
	assign remote_fall = int_prev_ff && !int_n_s;
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			int_prev_ff <= 1'b1;
			remote_pend_ff <= 1'b0;
			REMOTE_INTERRUPT_MIRROR_N <= 1'b0;
			LOCAL_INTERRUPT_N <= 1'b1;
		end else begin
			int_prev_ff <= int_n_s;
			REMOTE_INTERRUPT_MIRROR_N <= lock_s && int_n_s; // see [R11] [R12]
			if (remote_fall && icr_ff[REMOTE_IRQ_ROUTE_BIT] && icr_ff[INT_GLOBAL_EN_BIT]) begin
				remote_pend_ff <= 1'b1; // see [R13] [R16]
			end else if (isr_read) begin
				remote_pend_ff <= 1'b0; // see [R14] [R15]
			end
			LOCAL_INTERRUPT_N <= !(remote_pend_ff && icr_ff[INT_GLOBAL_EN_BIT]); // see [R13]
		end
	end

	// Per-line nibbles: GPIO 0..3, then general outputs 4..7
	assign mode18 = depth_ff[MODE18_BIT];
	assign DOWNSTREAM_18BIT = mode18; // see [R19]
	assign line_cfg[0] = gpio0_ff[3:0];
	assign line_cfg[1] = gpio12_ff[3:0];
	assign line_cfg[2] = gpio12_ff[7:4];
	assign line_cfg[3] = gpio3_ff[3:0];
	assign line_cfg[4] = gpio3_ff[7:4];
	assign line_cfg[5] = out56_ff[3:0];
	assign line_cfg[6] = out56_ff[7:4];
	assign line_cfg[7] = out7_ff[3:0];

	// Lines only act in 18-bit mode, where the low red and green pins are free
	for (genvar i = 0; i < 8; i++) begin : g_line
		logic pin_lvl;
		logic back_lvl;
		logic act;
		if (i < 4) begin : g_gpio
			// GPIO lines share the two lowest red and green pixel pins
			assign pin_lvl = (i < 2) ? data_s[16 + i] : data_s[8 + i - 2]; // see [R18]
			assign back_lvl = back_gpio_s[i];
		end else begin : g_gpo
			// General output lines have no back channel source
			assign pin_lvl = line_in_s[i];
			assign back_lvl = 1'b0;
		end
		assign act = mode18 && line_cfg[i][LINE_EN_BIT];
		always_ff @(posedge CLOCK or negedge ARST_N) begin
			if (!ARST_N) begin
				LINE_OUT[i] <= 1'b0;
				LINE_OE[i] <= 1'b0;
				FWD_LINE[i] <= 1'b0;
			end else if (i < 4) begin
				LINE_OE[i] <= act && line_cfg[i][LINE_BACK_BIT]; // see [R18]
				LINE_OUT[i] <= back_lvl;
				FWD_LINE[i] <= act && line_cfg[i][LINE_FWD_BIT] && pin_lvl;
			end else begin
				LINE_OE[i] <= act && !line_cfg[i][LINE_FWD_BIT]; // see [R22]
				LINE_OUT[i] <= line_cfg[i][LINE_VAL_BIT]; // see [R22]
				FWD_LINE[i] <= act && line_cfg[i][LINE_FWD_BIT] && pin_lvl; // see [R21]
			end
		end
	end

	default clocking @(posedge CLOCK); endclocking
	default disable iff (!ARST_N);

	a_apd_sleep_entry: assert property ((apd_ff == APD_RUN && dev_ctl_ff[APD_ENABLE_BIT] && !bc_s) // see [R01]
		|=> APD_LOW_POWER && !FORWARD_ENABLE)
		else $error("auto power-down not entered");
	a_apd_resume_cause: assert property ($rose(FORWARD_ENABLE) |-> !$past(dev_ctl_ff[APD_ENABLE_BIT])) // see [R02]
		else $error("forward channel resumed with enable set");
	a_pclk_loss_sleep: assert property ((loss_cnt_ff == 8'(PCLK_LOSS_CYCLES - 1) // see [R04] [R05]
		&& !pclk_rise && !pclk_fall && clk_ctl_ff[SLEEP_ON_LOSS_BIT]) |=> PCLK_SLEEP)
		else $error("no sleep after pixel clock loss");
	a_pclk_relock: assert property ((pclk_rise || pclk_fall) |=> !pclk_lost_ff ##1 !PCLK_SLEEP) // see [R06]
		else $error("pixel clock not relocked");
	a_link_fault: assert property ((|fault_s) |=> !link_ok_ff) // see [R08]
		else $error("link detect set during fault");
	a_capture_edge: assert property ((clk_ctl_ff[EDGE_SELECT_BIT] && pclk_rise) // see [R09]
		|=> CAPTURED_DATA == $past(data_s))
		else $error("rising edge capture missed");
	a_capture_fall: assert property ((!clk_ctl_ff[EDGE_SELECT_BIT] && pclk_fall) // see [R09]
		|=> CAPTURED_DATA == $past(data_s))
		else $error("falling edge capture missed");
	a_band_high: assert property ((frequency_band_pin_eff && !alt_eff) |-> HIGH_BAND_SETTING && !MIDDLE_BAND_SETTING) // see [R10]
		else $error("wrong band selected");
	a_mirror_follow: assert property (lock_s |=> REMOTE_INTERRUPT_MIRROR_N == $past(int_n_s)) // see [R11]
		else $error("mirror does not follow remote interrupt");
	a_mirror_unlocked: assert property (!lock_s |=> !REMOTE_INTERRUPT_MIRROR_N) // see [R12]
		else $error("mirror released before lock");
	a_local_irq_set: assert property ((remote_fall && icr_ff[REMOTE_IRQ_ROUTE_BIT] // see [R13]
		&& icr_ff[INT_GLOBAL_EN_BIT]) |-> ##2 !LOCAL_INTERRUPT_N)
		else $error("routed remote interrupt not raised");
	a_isr_read_clear: assert property ((isr_read && !remote_fall) |=> !remote_pend_ff ##1 LOCAL_INTERRUPT_N) // see [R14]
		else $error("status read did not release interrupt");
	a_gpo_drive: assert property ((mode18 && out7_ff[3:0] == 4'h9) |=> LINE_OE[7] && LINE_OUT[7]) // see [R22]
		else $error("general output 7 not driven high");
endmodule : serializer_sideband_control

//--- src/sideband_i2c_slave.sv
// I2C target with register pointer and auto-increment
module sideband_i2c_slave
	import sideband_pkg::*;
	#(
	parameter logic [6:0] DEV_ADDR = 7'h0C // Arbitrary bus address
)(
	input wire logic clk, // System clock
	input wire logic arst_n, // Asynchronous reset, active low
	input wire logic scl, // Synchronised SCL
	input wire logic sda, // Synchronised SDA
	output logic sda_oe, // Pull SDA low
	output logic wr_en, // Register write pulse
	output logic rd_en, // Register fetch pulse
	output logic [7:0] addr, // Register pointer
	output logic [7:0] wdata, // Write data
	input wire logic [7:0] rdata // Read data at pointer
);
	typedef enum logic [3:0] {S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK, S_WDATA, S_WDATA_ACK,
		S_RDATA, S_RDATA_ACK} i2c_state_t;
	i2c_state_t state_ff;
	logic scl_prev_ff, sda_prev_ff, rw_ff, nack_ff;
	logic [3:0] cnt_ff;
	logic [7:0] sh_ff;
	logic start_cond, stop_cond, scl_rise, scl_fall;

	assign start_cond = scl && scl_prev_ff && sda_prev_ff && !sda;
	assign stop_cond = scl && scl_prev_ff && !sda_prev_ff && sda;
	assign scl_rise = scl && !scl_prev_ff;
	assign scl_fall = !scl && scl_prev_ff;

	// Bus edge history
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end else begin
			scl_prev_ff <= scl;
			sda_prev_ff <= sda;
		end
	end

	// Protocol engine; bits shift on SCL rise, SDA changes on SCL fall
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= S_IDLE;
			cnt_ff <= 4'h0;
			sh_ff <= 8'h00;
			rw_ff <= 1'b0;
			nack_ff <= 1'b0;
			sda_oe <= 1'b0;
			wr_en <= 1'b0;
			rd_en <= 1'b0;
			addr <= 8'h00;
			wdata <= 8'h00;
		end else begin
			wr_en <= 1'b0;
			rd_en <= 1'b0;
			if (start_cond) begin
				state_ff <= S_ADDR;
				cnt_ff <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop_cond) begin
				state_ff <= S_IDLE;
				sda_oe <= 1'b0;
			end else if (scl_rise) begin
				if (state_ff == S_ADDR || state_ff == S_PTR || state_ff == S_WDATA) begin
					sh_ff <= {sh_ff[6:0], sda};
					cnt_ff <= cnt_ff + 4'h1;
				end
				if (state_ff == S_RDATA_ACK) nack_ff <= sda;
			end else if (scl_fall) begin
				case (state_ff)
					S_ADDR: if (cnt_ff == 4'h8) begin
						if (sh_ff[7:1] == DEV_ADDR) begin
							state_ff <= S_ADDR_ACK;
							sda_oe <= 1'b1;
							rw_ff <= sh_ff[0];
						end else state_ff <= S_IDLE;
					end
					S_PTR, S_WDATA: if (cnt_ff == 4'h8) begin
						state_ff <= (state_ff == S_PTR) ? S_PTR_ACK : S_WDATA_ACK;
						sda_oe <= 1'b1;
						if (state_ff == S_PTR) addr <= sh_ff;
						else begin
							wdata <= sh_ff;
							wr_en <= 1'b1;
						end
					end
					S_ADDR_ACK, S_PTR_ACK, S_WDATA_ACK, S_RDATA_ACK: begin
						cnt_ff <= 4'h0;
						sda_oe <= 1'b0;
						if (state_ff == S_WDATA_ACK) addr <= addr + 8'h01;
						if (state_ff == S_PTR_ACK || state_ff == S_WDATA_ACK) state_ff <= S_WDATA;
						else if (state_ff == S_ADDR_ACK && !rw_ff) state_ff <= S_PTR;
						else if (state_ff == S_RDATA_ACK && nack_ff) state_ff <= S_IDLE;
						else begin
							// Fetch a byte: the fetch pulse carries read side effects
							state_ff <= S_RDATA;
							sh_ff <= rdata;
							sda_oe <= !rdata[7];
							rd_en <= 1'b1;
							cnt_ff <= 4'h1;
						end
					end
					S_RDATA: if (cnt_ff == 4'h8) begin
						state_ff <= S_RDATA_ACK;
						sda_oe <= 1'b0;
						addr <= addr + 8'h01;
					end else begin
						sh_ff <= {sh_ff[6:0], 1'b0};
						sda_oe <= !sh_ff[6];
						cnt_ff <= cnt_ff + 4'h1;
					end
					default: ;
				endcase
			end
		end
	end
endmodule : sideband_i2c_slave

//--- src/sideband_pkg.sv
// Constants shared by the serializer sideband control block
package sideband_pkg;
	// Register offsets
	localparam logic [7:0] OFS_DEVICE_CONTROL = 8'h01;
	localparam logic [7:0] OFS_CLOCK_LOSS_CONTROL = 8'h03;
	localparam logic [7:0] OFS_ALT_FREQ_OVERRIDE = 8'h04;
	localparam logic [7:0] OFS_LINK_STATUS = 8'h0C;
	localparam logic [7:0] OFS_GPIO0_CONFIG = 8'h0D;
	localparam logic [7:0] OFS_GPIO1_2_CONFIG = 8'h0E;
	localparam logic [7:0] OFS_GPIO3_OUT4_CONFIG = 8'h0F;
	localparam logic [7:0] OFS_OUT5_6_CONFIG = 8'h10;
	localparam logic [7:0] OFS_OUT7_CONFIG = 8'h11;
	localparam logic [7:0] OFS_COLOUR_DEPTH = 8'h12;
	localparam logic [7:0] OFS_FREQ_SEL_OVERRIDE = 8'h35;
	localparam logic [7:0] OFS_INTERRUPT_CONTROL = 8'hC6;
	localparam logic [7:0] OFS_INTERRUPT_STATUS = 8'hC7;
	// Reset values
	localparam logic [7:0] RST_DEVICE_CONTROL = 8'h00;
	localparam logic [7:0] RST_CLOCK_LOSS_CONTROL = 8'h01;
	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
	// Field positions
	localparam int APD_ENABLE_BIT = 7;
	localparam int EDGE_SELECT_BIT = 0;
	localparam int SLEEP_ON_LOSS_BIT = 1;
	localparam int PATTERN_ENABLE_BIT = 3;
	localparam int PATTERN_OSC_BIT = 4;
	localparam int ALT_OVR_EN_BIT = 1;
	localparam int ALT_OVR_VAL_BIT = 0;
	localparam int FREQUENCY_BAND_PIN_OVR_EN_BIT = 7;
	localparam int FREQUENCY_BAND_PIN_OVR_VAL_BIT = 6;
	localparam int LINK_DETECT_BIT = 0;
	localparam int PCLK_PRESENT_BIT = 1;
	localparam int MODE18_BIT = 2;
	localparam int INT_GLOBAL_EN_BIT = 0;
	localparam int REMOTE_IRQ_ROUTE_BIT = 5;
	localparam int ISR_ANY_BIT = 0;
	localparam int ISR_REMOTE_BIT = 5;
	// Line configuration nibble
	localparam int LINE_EN_BIT = 0;
	localparam int LINE_FWD_BIT = 1;
	localparam int LINE_BACK_BIT = 2;
	localparam int LINE_VAL_BIT = 3;
	// Pixel clock loss timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int PCLK_LOSS_NS = 1000;
	localparam int PCLK_LOSS_CYCLES = PCLK_LOSS_NS / CLK_PERIOD_NS;
	// Synchroniser: width and idle levels (SCL, SDA, remote interrupt idle high)
	localparam int SYNC_W = 46;
	localparam logic [SYNC_W-1:0] SYNC_RST = 46'h3002_0000_0000;
	typedef enum logic [1:0] {APD_RUN, APD_SLEEP, APD_WAKE} apd_state_t;
endpackage : sideband_pkg

//--- src/sideband_sync.sv
// Two-flop synchroniser for a group of asynchronous pins
module sideband_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
)(
	input wire logic clk, // System clock
	input wire logic arst_n, // Asynchronous reset, active low
	input wire logic [W-1:0] din, // Asynchronous inputs
	output logic [W-1:0] dout // Synchronised outputs
);
	logic [W-1:0] meta_ff;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_ff <= RST_VAL;
			dout <= RST_VAL;
		end else begin
			meta_ff <= din;
			dout <= meta_ff;
		end
	end
endmodule : sideband_sync

//--- verification/i2c_host_model.sv
// Bit-banged local I2C host for the sideband register bank
module i2c_host_model (
	input wire logic clk, // System clock
	input wire logic sda_in, // Wired SDA level
	output logic scl, // I2C clock
	output logic sda_low // Pull SDA low
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Quarter bit of eight cycles leaves room for the two-flop sync
	task automatic q();
		repeat (8) @(negedge clk);
	endtask : q
	// SDA moves only while SCL is low
	task automatic bit_io(input logic b, output logic r);
		sda_low = ~b;
		q();
		scl = 1'b1;
		q();
		r = sda_in;
		q();
		scl = 1'b0;
		q();
	endtask : bit_io
	// Ninth bit released: ACK on writes, NACK ends a read
	task automatic byte_io(input logic [7:0] b, output logic [7:0] r, output logic nak);
		for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
		bit_io(1'b1, nak);
	endtask : byte_io
	task automatic edge_cond(input logic stop);
		sda_low = 1'b1;
		q();
		scl = stop;
		q();
		sda_low = ~stop;
		q();
	endtask : edge_cond
	// Pointer write, then data byte or a fresh read frame
	task automatic access(input logic rd, input logic [7:0] ofs, input logic [7:0] wd, output logic [7:0] r);
		logic [7:0] x;
		logic n;
		scl = 1'b1;
		edge_cond(1'b0);
		byte_io(8'h18, x, n);
		byte_io(ofs, x, n);
		if (!rd) byte_io(wd, x, n);
		edge_cond(1'b1);
		if (rd) begin
			edge_cond(1'b0);
			byte_io(8'h19, x, n);
			byte_io(8'hFF, r, n);
			edge_cond(1'b1);
		end
	endtask : access
endmodule : i2c_host_model

//--- verification/serializer_sideband_control_tb.sv
// Self-checking bench for the sideband register bank
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch %s exp %0h got %0h", n, e, g); end end
module serializer_sideband_control_tb;
	import sideband_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, arst_n = 1'b0, rwr = 1'b0, prun = 1'b1, bcd = 1'b1, lock = 1'b0, irq_n = 1'b1;
	logic frequency_band_pin = 1'b0, alt = 1'b0, pclk, scl, sda_low, sda_oe, sda, loc_n, mir_n, hb, mb, lb, fwd, apd, rty, slp, d18;
	logic [7:0] raddr = 8'h00, rwd = 8'h00, rdat, lout, loe, fl;
	logic [3:0] lin = 4'h0, bgp = 4'h0;
	logic pat, osc;
	logic [5:0] fault = 6'h00;
	logic [2:0] div = 3'h0;
	logic [23:0] pix = 24'hA5C3E1, cap;
	int n_mismatch = 0, cmp_count = 0;
	always #5 clk = ~clk;
	// Pixel clock at an eighth of the system rate, stoppable
	always @(negedge clk) if (prun) div <= div + 3'h1;
	assign pclk = div[2];
	assign sda = ~(sda_low | sda_oe); // Pulled up open-drain line
	serializer_sideband_control dut (.CLOCK(clk), .ARST_N(arst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OE(sda_oe),
		.SDA_OUT(), .REMOTE_WR_EN(rwr), .REMOTE_ADDR(raddr), .REMOTE_WDATA(rwd), .PCLK_IN(pclk), .PIXEL_DATA(pix),
		.CAPTURED_DATA(cap), .BACK_CHANNEL_DET(bcd), .LINK_FAULT(fault), .DOWNSTREAM_LOCK(lock),
		.DOWNSTREAM_INTERRUPT_IN_N(irq_n), .REMOTE_INTERRUPT_MIRROR_N(mir_n), .LOCAL_INTERRUPT_N(loc_n),
		.FREQUENCY_BAND_PIN(frequency_band_pin), .ALT_FREQ_PIN(alt), .HIGH_BAND_SETTING(hb), .MIDDLE_BAND_SETTING(mb),
		.LOW_BAND_SETTING(lb), .FORWARD_ENABLE(fwd), .APD_LOW_POWER(apd), .APD_RETRY(rty), .PCLK_SLEEP(slp),
		.TX_PATTERN(pat), .TX_USE_OSC(osc), .DOWNSTREAM_18BIT(d18), .BACK_GPIO(bgp), .LINE_IN(lin), .LINE_OUT(lout),
		.LINE_OE(loe), .FWD_LINE(fl));
	i2c_host_model host (.clk(clk), .sda_in(sda), .scl(scl), .sda_low(sda_low));
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		host.access(1'b0, ofs, d, rdat);
	endtask : wr
	task automatic rd(input logic [7:0] ofs);
		host.access(1'b1, ofs, 8'h00, rdat);
	endtask : rd
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	// Pin combinations first, then both register overrides
	task automatic t_band();
		logic [2:0] exp [4] = '{3'b100, 3'b001, 3'b100, 3'b010};
		for (int i = 0; i < 4; i++) begin
			{frequency_band_pin, alt} = 2'(i);
			cyc(4);
			`CHK("band", exp[i], {hb, mb, lb})
		end
		{frequency_band_pin, alt} = 2'b10;
		wr(OFS_ALT_FREQ_OVERRIDE, 8'h03);
		wr(OFS_FREQ_SEL_OVERRIDE, 8'h80);
		`CHK("band ovr", 3'b001, {hb, mb, lb})
		$display("test band done");
	endtask : t_band
	task automatic t_irq();
		irq_n = 1'b0;
		cyc(6);
		`CHK("mirror unlocked", 1'b0, mir_n)
		lock = 1'b1;
		irq_n = 1'b1;
		cyc(6);
		`CHK("mirror", 1'b1, mir_n)
		rd(OFS_INTERRUPT_STATUS);
		// Mirror user: routing bit left low, local pin must stay quiet
		wr(OFS_INTERRUPT_CONTROL, 8'h01);
		irq_n = 1'b0;
		cyc(6);
		`CHK("masked", 2'b01, {mir_n, loc_n})
		irq_n = 1'b1;
		wr(OFS_INTERRUPT_CONTROL, 8'h21);
		irq_n = 1'b0;
		cyc(6);
		`CHK("mirror", 1'b0, mir_n)
		`CHK("local irq", 1'b0, loc_n)
		rd(OFS_INTERRUPT_STATUS);
		`CHK("status", 8'h21, rdat)
		`CHK("local irq", 1'b1, loc_n)
		irq_n = 1'b1;
		$display("test irq done");
	endtask : t_irq
	// Sleep without back channel, wake cleared over the back channel
	task automatic t_apd();
		bcd = 1'b0;
		wr(OFS_DEVICE_CONTROL, 8'h80);
		cyc(4);
		`CHK("asleep", 2'b10, {apd, fwd})
		bcd = 1'b1;
		cyc(4);
		`CHK("retry", 2'b10, {rty, fwd})
		raddr = OFS_DEVICE_CONTROL;
		rwr = 1'b1;
		cyc(1);
		rwr = 1'b0;
		cyc(3);
		`CHK("resumed", 1'b1, fwd)
		$display("test apd done");
	endtask : t_apd
	task automatic t_misc();
		rd(8'h50);
		`CHK("unmapped", 8'h00, rdat)
		for (int i = 0; i < 7; i++) begin
			fault = (i < 6) ? 6'(1 << i) : 6'h00;
			rd(OFS_LINK_STATUS);
			`CHK("link", i == 6, rdat[LINK_DETECT_BIT])
		end
		wr(OFS_COLOUR_DEPTH, 8'h04);
		wr(OFS_OUT7_CONFIG, 8'h09);
		`CHK("18 bit", 1'b1, d18)
		`CHK("out7", 2'b11, {lout[7], loe[7]})
		wr(OFS_OUT7_CONFIG, 8'h01);
		wr(OFS_OUT5_6_CONFIG, 8'h90);
		`CHK("out7 out6", 3'b011, {lout[7], lout[6], loe[6]})
		// GPIO3 forward, general output 4 as input, GPIO2 back channel
		lin = 4'h1;
		bgp = 4'h4;
		wr(OFS_GPIO3_OUT4_CONFIG, 8'h33);
		wr(OFS_GPIO1_2_CONFIG, 8'h50);
		`CHK("lines", 6'b110011, {fl[4:3], loe[4:2], lout[2]})
		$display("test misc done");
	endtask : t_misc
	// Loss needs 100 quiet cycles; the figure is checked from both sides
	task automatic t_pclk();
		`CHK("capture rise", pix, cap)
		pix = 24'h5A3C1E;
		wr(OFS_CLOCK_LOSS_CONTROL, 8'h1A);
		`CHK("capture fall", 24'h5A3C1E, cap)
		`CHK("pattern", 2'b10, {pat, osc})
		prun = 1'b0;
		cyc(90);
		`CHK("not lost", 1'b0, slp)
		cyc(30);
		`CHK("sleep", 3'b111, {slp, pat, osc})
		prun = 1'b1;
		cyc(12);
		`CHK("relock", 2'b00, {slp, osc})
		rd(OFS_CLOCK_LOSS_CONTROL);
		`CHK("retained", 8'h1A, rdat)
		$display("test pclk done");
	endtask : t_pclk
	initial begin
		cyc(12);
		arst_n = 1'b1;
		cyc(4);
		t_band();
		t_irq();
		t_apd();
		t_misc();
		t_pclk();
		give_verdict();
	end
	initial begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		give_verdict();
	end
endmodule : serializer_sideband_control_tb
